//--- verification/vems_checker.sv
// Purpose: port assertions for vems_top
// Assumes: one clock, sync active low reset
// Notes: bound after the module
`timescale 1ns/1ps
`default_nettype none
module vems_checker (
  // watched ports
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire [1:0] reg_sel_i,
  input wire reg_rd_i,
  input wire reg_wr_i,
  input wire [31:0] reg_rdata_o,
  input wire reg_rvalid_o,
  input wire eoi_mode_i,
  input wire end_of_interrupt_write_i,
  input wire virtual_deactivate_write_i,
  input wire [31:0] deact_intid_i,
  input wire deact_intid_valid_i,
  input wire deact_is_sgi_i,
  input wire phys_deactivate_write_i,
  input wire deactivate_trap_o,
  input wire other_maint_i,
  input wire virt_irq_req_i,
  input wire maint_irq_o,
  input wire virt_irq_o,
  input wire [4:0] overflow_count_o
);
  wire ok = !reg_wr_i && !deact_is_sgi_i && deact_intid_valid_i && deact_intid_i < 32'h00002000;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // ---
  // checks
  // ---
  chk_eoi_count: assert property (ok && !eoi_mode_i && end_of_interrupt_write_i
    |=> overflow_count_o == $past(overflow_count_o) + 5'h01) else $error("eoi not counted");
  chk_deact_count: assert property (ok && eoi_mode_i && virtual_deactivate_write_i
    |=> overflow_count_o == $past(overflow_count_o) + 5'h01) else $error("dir not counted");
  chk_count_hold: assert property (!reg_wr_i && !end_of_interrupt_write_i
    && !virtual_deactivate_write_i |=> $stable(overflow_count_o)) else $error("count moved");
  chk_big_id: assert property (deact_intid_i >= 32'h00002000 && !reg_wr_i
    |=> $stable(overflow_count_o)) else $error("large id counted");
  chk_upper_zero: assert property (reg_rd_i && reg_sel_i != 2'h2
    |=> reg_rvalid_o && reg_rdata_o[31:16] == 16'h0000) else $error("upper half set");
  chk_trap_cause: assert property (deactivate_trap_o
    |-> virtual_deactivate_write_i || phys_deactivate_write_i) else $error("stray trap");
  chk_reset_clear: assert property ($rose(rst_n_i)
    |-> overflow_count_o == 5'h00 && !maint_irq_o) else $error("reset not clear");
  chk_maint_gate: assert property ($past(overflow_count_o) == 5'h00 && !$past(other_maint_i)
    |-> !maint_irq_o) else $error("maint without cause");
  chk_virt_gate: assert property (virt_irq_o |-> $past(virt_irq_req_i))
    else $error("virt irq without request");
endmodule
bind vems_top vems_checker i_chk (.*);
`default_nettype wire

//--- verification/virtual_eoi_maintenance_status_test.sv
// Purpose: self-checking bench for vems_top
// Assumes: 200 MHz clock, sync reset
// Notes: event pulses model the no-entry-found case
`timescale 1ns/1ps
`default_nettype none
module virtual_eoi_maintenance_status_test;
  logic clk_sys_i = 1'h0, rst_n_i = 1'h0, reg_rd_i = 1'h0, reg_wr_i = 1'h0, eoi_mode_i = 1'h0;
  logic end_of_interrupt_write_i = 1'h0, virtual_deactivate_write_i = 1'h0;
  logic deact_intid_valid_i = 1'h1, deact_is_sgi_i = 1'h0, phys_deactivate_write_i = 1'h0;
  logic other_maint_i = 1'h0, virt_irq_req_i = 1'h1;
  logic [1:0] reg_sel_i = 2'h0;
  logic [31:0] reg_wdata_i = 32'h0, deact_intid_i = 32'h0;
  logic [159:0] list_entry_i = 160'h0;
  wire [31:0] reg_rdata_o;
  wire reg_rvalid_o, deactivate_trap_o, maint_irq_o, virt_irq_o;
  wire [4:0] overflow_count_o;
  int failures = 0, samples_checked = 0;
  vems_top i_dut (.*);
  always #2.5 clk_sys_i = ~clk_sys_i;
  // ---
  // tasks
  // ---
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [1:0] s, input logic [31:0] exp);
    @(posedge clk_sys_i);
    reg_sel_i <= s;
    reg_rd_i <= 1'h1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'h0;
    #1 chk(reg_rvalid_o, 32'h1);
    chk(reg_rdata_o, exp);
  endtask
  task automatic wr(input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_sel_i <= 2'h2;
    reg_wr_i <= 1'h1;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'h0;
  endtask
  task automatic ev(input logic [3:0] k, input logic [31:0] id);
    @(posedge clk_sys_i);
    {eoi_mode_i, deact_is_sgi_i, virtual_deactivate_write_i, end_of_interrupt_write_i} <= k;
    deact_intid_i <= id;
    @(posedge clk_sys_i);
    {deact_is_sgi_i, virtual_deactivate_write_i, end_of_interrupt_write_i} <= 3'h0;
  endtask
  task automatic t_status;
    rd(2'h2, 32'h00000000);
    @(posedge clk_sys_i);
    list_entry_i <= {120'h0, 10'h000, 10'h201, 10'h204, 10'h200};
    rd(2'h0, 32'h00000001);
    rd(2'h1, 32'h0000FFFA);
    rd(2'h3, 32'h00000000);
  endtask
  task automatic t_trap;
    wr(32'hFFFFFFFF);
    rd(2'h2, 32'hF8004105);
    chk(virt_irq_o, 32'h1);
    chk(maint_irq_o, 32'h1);
    @(posedge clk_sys_i);
    virtual_deactivate_write_i <= 1'h1;
    #1 chk(deactivate_trap_o, 32'h1);
    @(posedge clk_sys_i);
    virtual_deactivate_write_i <= 1'h0;
    phys_deactivate_write_i <= 1'h1;
    #1 chk(deactivate_trap_o, 32'h1);
    wr(32'h00000000);
    #1 chk(deactivate_trap_o, 32'h0);
    @(posedge clk_sys_i);
    phys_deactivate_write_i <= 1'h0;
  endtask
  task automatic t_count;
    wr(32'h00000005);
    ev(4'h1, 32'h00000005);
    ev(4'h1, 32'h00002000);
    rd(2'h2, 32'h08000005);
    chk(overflow_count_o, 32'h1);
    chk(maint_irq_o, 32'h1);
    ev(4'hA, 32'h00000007);
    rd(2'h2, 32'h10000005);
    wr(32'hF8000105);
    ev(4'hE, 32'h00000003);
    rd(2'h2, 32'hF8000105);
    ev(4'hA, 32'h00000003);
    rd(2'h2, 32'h00000105);
    wr(32'h08000004);
    rd(2'h2, 32'h08000004);
    chk(maint_irq_o, 32'h0);
    chk(virt_irq_o, 32'h0);
  endtask
  task automatic tally_and_finish;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    t_status();
    t_trap();
    t_count();
    tally_and_finish();
  end
  initial
  begin
    #5000;
    failures++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

//--- verilog/vems_defines.vh
// Purpose: constants for the virtual eoi maintenance status block
// Assumes: 32-bit system register words
// Notes: select codes are local to this block
`ifndef VEMS_DEFINES_VH
`define VEMS_DEFINES_VH
// register selects
`define VEMS_SEL_EOI_STATUS 2'h0
`define VEMS_SEL_EMPTY_STATUS 2'h1
`define VEMS_SEL_HV_CONTROL 2'h2
// control field positions
`define VEMS_CTL_CNT_HI 31
`define VEMS_CTL_CNT_LO 27
`define VEMS_CTL_TRAP_BIT 14
`define VEMS_CTL_SGI_BIT 8
`define VEMS_CTL_LRENP_BIT 2
`define VEMS_CTL_EN_BIT 0
// writable mask for implemented control bits
`define VEMS_CTL_WMASK 32'hF8004105
// list entry fields
`define VEMS_LE_STATE_HI 1
`define VEMS_LE_STATE_LO 0
`define VEMS_LE_HW_BIT 2
`define VEMS_LE_EOI_BIT 9
`define VEMS_STATE_INVALID 2'h0
// identifier limit
`define VEMS_LPI_BASE 32'h00002000
// reset value
`define VEMS_CTL_RESET 32'h00000000
`endif

//--- verilog/vems_status_slice.v
// Purpose: per list entry eoi and empty status decode
// Assumes: entry word holds state, hardware link and eoi request bits
// Notes: unimplemented entries read zero in both vectors
`timescale 1ns/1ps
`default_nettype none
`include "vems_defines.vh"
module vems_status_slice #(
  parameter NUM_LR = 16
) (
  // entry fields
  input wire [NUM_LR*10-1:0] entry_bits_i,
  // status
  output wire [15:0] eoi_vec_o,
  output wire [15:0] empty_vec_o
);
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1)
    begin : g_lr
      if (g < NUM_LR)
      begin : g_impl
        wire [9:0] e;
        wire idle;
        assign e = entry_bits_i[g*10 +: 10];
        assign idle = (e[`VEMS_LE_STATE_HI:`VEMS_LE_STATE_LO] == `VEMS_STATE_INVALID);
        assign eoi_vec_o[g] = idle & ~e[`VEMS_LE_HW_BIT] & e[`VEMS_LE_EOI_BIT];
        assign empty_vec_o[g] = idle & (e[`VEMS_LE_HW_BIT] | ~e[`VEMS_LE_EOI_BIT]);
      end
      else
      begin : g_none
        assign eoi_vec_o[g] = 1'b0;
        assign empty_vec_o[g] = 1'b0;
      end
    end
  endgenerate
endmodule
`default_nettype wire

//--- verilog/vems_top.v
// Purpose: hypervisor eoi maintenance status and control slice
// Assumes: system register port: select, read and write strobes, one clock
// Notes: deactivations with no list entry found arrive as one-cycle pulses
//
// Overview of operation
// - one eoi status bit per list entry in bits 15..0, upper half zero
// - eoi bit set when state idle, no hardware link, eoi request set
// - eoi bit 1 means maintenance still pending for that entry
// - empty bit set when state idle and hardware link or no eoi request
// - count eoi write, mode 0, id below 8192, no entry found
// - count deactivate write, mode 1, id below 8192, no entry found
// - eoi write clearing no active priority bit: we increment
// - trap bit 1 traps virtual deactivate writes; physical trapped too
// - trap bit 0 traps no deactivate writes
// - not-present enable asserts maintenance while counter nonzero
// - sgi count control 1 stops counting virtual sgi deactivation
// - global enable 0 silences maintenance and virtual interrupts
`timescale 1ns/1ps
`default_nettype none
`include "vems_defines.vh"
module vems_top #(
  parameter NUM_LR = 16
) (
  // clock and reset
  input wire clk_sys_i,
  input wire rst_n_i,
  // system register port
  input wire [1:0] reg_sel_i,
  input wire reg_rd_i,
  input wire reg_wr_i,
  input wire [31:0] reg_wdata_i,
  output reg [31:0] reg_rdata_o,
  output reg reg_rvalid_o,
  // list entries
  input wire [NUM_LR*10-1:0] list_entry_i,
  // deactivation events, no matching entry found
  input wire eoi_mode_i,
  input wire end_of_interrupt_write_i,
  input wire virtual_deactivate_write_i,
  input wire [31:0] deact_intid_i,
  input wire deact_intid_valid_i,
  input wire deact_is_sgi_i,
  // trap query from non-secure el1
  input wire phys_deactivate_write_i,
  output wire deactivate_trap_o,
  // interrupt outputs
  input wire other_maint_i,
  input wire virt_irq_req_i,
  output reg maint_irq_o,
  output reg virt_irq_o,
  output wire [4:0] overflow_count_o
);
  // ----------------------------------------
  // status decode
  // ----------------------------------------
  wire [15:0] eoi_vec;
  wire [15:0] empty_vec;
  vems_status_slice #(
    .NUM_LR(NUM_LR)
  ) u_slice (
    .entry_bits_i(list_entry_i),
    .eoi_vec_o(eoi_vec),
    .empty_vec_o(empty_vec)
  );
  reg [15:0] eoi_maintenance_status;
  always @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      eoi_maintenance_status <= 16'h0000;
    else
      eoi_maintenance_status <= eoi_vec;
  end
  // ----------------------------------------
  // control register
  // ----------------------------------------
  reg [31:0] hypervisor_virtual_control;
  wire [4:0] overflow_deactivation_counter;
  wire global_en;
  wire sgi_ctl;
  wire lrenp_en;
  assign overflow_deactivation_counter =
    hypervisor_virtual_control[`VEMS_CTL_CNT_HI:`VEMS_CTL_CNT_LO];
  assign global_en = hypervisor_virtual_control[`VEMS_CTL_EN_BIT];
  assign sgi_ctl = hypervisor_virtual_control[`VEMS_CTL_SGI_BIT];
  assign lrenp_en = hypervisor_virtual_control[`VEMS_CTL_LRENP_BIT];
  assign overflow_count_o = overflow_deactivation_counter;
  // ----------------------------------------
  // overflow counting
  // ----------------------------------------
  wire id_ok;
  wire cnt_eoi;
  wire cnt_dir;
  wire cnt_inc;
  assign id_ok = deact_intid_valid_i && (deact_intid_i < `VEMS_LPI_BASE);
  assign cnt_eoi = end_of_interrupt_write_i && !eoi_mode_i && id_ok;
  assign cnt_dir = virtual_deactivate_write_i && eoi_mode_i && id_ok;
  assign cnt_inc = (cnt_eoi || cnt_dir) && !(sgi_ctl && deact_is_sgi_i);
  reg [31:0] next_ctl;
  reg [4:0] next_cnt;
  always @*
  begin
    next_ctl = hypervisor_virtual_control;
    if (reg_wr_i && reg_sel_i == `VEMS_SEL_HV_CONTROL)
      next_ctl = reg_wdata_i & `VEMS_CTL_WMASK;
    next_cnt = next_ctl[`VEMS_CTL_CNT_HI:`VEMS_CTL_CNT_LO];
    if (cnt_inc)
      next_cnt = next_cnt + 5'h01;
    next_ctl[`VEMS_CTL_CNT_HI:`VEMS_CTL_CNT_LO] = next_cnt;
  end
  always @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      hypervisor_virtual_control <= `VEMS_CTL_RESET;
    else
      hypervisor_virtual_control <= next_ctl;
  end
  // ----------------------------------------
  // deactivate trap
  // ----------------------------------------
  assign deactivate_trap_o = hypervisor_virtual_control[`VEMS_CTL_TRAP_BIT] &&
    (virtual_deactivate_write_i || phys_deactivate_write_i);
  // ----------------------------------------
  // interrupt outputs
  // ----------------------------------------
  always @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      maint_irq_o <= 1'b0;
      virt_irq_o <= 1'b0;
    end
    else
    begin
      maint_irq_o <= global_en &&
        ((lrenp_en && overflow_deactivation_counter != 5'h00) || other_maint_i);
      virt_irq_o <= global_en && virt_irq_req_i;
    end
  end
  // ----------------------------------------
  // register reads
  // ----------------------------------------
  reg [31:0] rd_mux;
  always @*
  begin
    if (reg_sel_i == `VEMS_SEL_EOI_STATUS)
      rd_mux = {16'h0000, eoi_maintenance_status};
    else if (reg_sel_i == `VEMS_SEL_EMPTY_STATUS)
      rd_mux = {16'h0000, empty_vec};
    else if (reg_sel_i == `VEMS_SEL_HV_CONTROL)
      rd_mux = hypervisor_virtual_control;
    else
      rd_mux = 32'h00000000;
  end
  always @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      reg_rdata_o <= 32'h00000000;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
        reg_rdata_o <= rd_mux;
    end
  end
endmodule
`default_nettype wire
